// ---- sfsup_map.vh ----
// constants for the supply fault supervisor
// Notes on behaviour
// RL1: startup source on by supply level, off once turn-on level reached.
// RL2: startup source also re-enabled by bulk_ok rise, recovery end, thermal end.
// RL3: self-supply mode cycles supply between thresholds, no drive while ramping up.
// RL4: two startup current levels selectable; low level survives supply short.
// RL5: die-hot flag progressively reduces the high startup current level.
// RL6: after turn-on, hysteresis sink on while bulk_ok low, off while bulk_ok high.
// RL7: bulk pin held low during startup; released and sink enabled at turn-on.
// RL8: filtered brown-out result permits or inhibits the power stage.
// RL9: digital filter after brown-out comparator rejects short glitches.
// RL10: front-stage bias removed during light load and fault operation.
// RL11: switching only inside protection window; stop after filter delay outside.
// RL12: window fault latches or starts recovery timer per build option.
// RL13: over-voltage and over-temperature comparators each have own filter.
// RL14: over-temperature comparator ignored during startup blanking period.
// RL15: boost setting doubles thermistor bias to charge filter capacitor.
// RL16: protection bias on at first turn-on, bulk_ok, recovery restart, skip exit.
// RL17: bias off at turn-off, bulk_ok low, fault, skip entry.
// RL18: build option keeps protection block biased during skip.
// RL19: latched mode self-supplies without drive; only reset level clears it.
// RL20: one shared recovery timer of about one second for all faults; code times only non-latching window faults, thermal end restarts at once.
// RL21: filters are counters; change after full persistence, restart on contrary.
// RL22: supply below reset level asynchronously resets all supervisory state.
`ifndef SFSUP_MAP_VH
`define SFSUP_MAP_VH
`define SFSUP_CLK_MHZ        100
`define SFSUP_BULK_FILT_US   20
`define SFSUP_OVP_FILT_US    20
`define SFSUP_OTP_FILT_US    20
`define SFSUP_OTP_BLANK_US   1000
`define SFSUP_OTP_BOOST_US   500
`define SFSUP_RECOVER_MS     1000
`define SFSUP_RAMP_STEP_US   100
`define SFSUP_CNT(us)        ((us) * `SFSUP_CLK_MHZ)
`define SFSUP_ST_OFF         3'h0
`define SFSUP_ST_START       3'h1
`define SFSUP_ST_RUN         3'h2
`define SFSUP_ST_RECOVER     3'h3
`define SFSUP_ST_LATCH       3'h4
`define SFSUP_ST_SELF        3'h5
`define SFSUP_LIMIT_MAX      4'hf
`endif

// ---- sfsup_filter.v ----
// persistence filter for one comparator level
`default_nettype none
module sfsup_filter #(
    parameter W     = 32,
    parameter COUNT = 2000
) (
    // clock and reset
    input  wire         i_mclk,
    input  wire         i_reset,
    // raw level and filtered state
    input  wire         i_raw,
    output reg          o_state
);
    reg [W-1:0] cnt_r;

    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cnt_r   <= {W{1'b0}};
            o_state <= 1'b0;
        end else if (i_raw == o_state) begin
            cnt_r <= {W{1'b0}};                         // see RL21
        end else if (cnt_r >= COUNT - 1) begin
            cnt_r   <= {W{1'b0}};
            o_state <= i_raw;                           // see RL21
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- sfsup_supervisor.v ----
// supply, brown-out and protection-window supervisor
`include "sfsup_map.vh"
`default_nettype none
module sfsup_supervisor #(
    parameter OVP_LATCH      = 1,
    parameter OTP_LATCH      = 0,
    parameter BIAS_IN_SKIP   = 1,
    parameter RECOVER_CYCLES = `SFSUP_CNT(`SFSUP_RECOVER_MS * 1000),
    parameter BLANK_CYCLES   = `SFSUP_CNT(`SFSUP_OTP_BLANK_US),
    parameter BOOST_CYCLES   = `SFSUP_CNT(`SFSUP_OTP_BOOST_US),
    parameter STEP_CYCLES    = `SFSUP_CNT(`SFSUP_RAMP_STEP_US)
) (
    // clock and reset (reset = supply below reset level)
    input  wire         i_mclk,
    input  wire         i_reset,
    // supply comparators
    input  wire         i_supply_turn_on_level,
    input  wire         i_supply_turn_off_level,
    // brown-out comparator
    input  wire         i_bulk_cmp,
    // protection pin comparators
    input  wire         i_overvoltage_level,
    input  wire         i_overtemp_level,
    // other events
    input  wire         i_thermal_shutdown,
    input  wire         i_die_hot,
    input  wire         i_skip_entry_level,
    input  wire         i_skip_exit_level,
    input  wire         i_light_load,
    input  wire         i_low_current_sel,
    // startup source
    output reg          o_startup_on,
    output reg          o_startup_current_low,
    output reg          o_startup_current_high,
    output reg  [3:0]   o_startup_high_limit,
    // brown-out
    output reg          o_bulk_ok,
    output reg          o_bulk_hysteresis_sink,
    output reg          o_bulk_discharge,
    // protection pin
    output reg          o_protection_bias,
    output reg          o_thermistor_bias_doubled,
    // power stage
    output reg          o_drive_enable,
    output reg          o_self_supply_mode,
    output reg          o_fault_latched,
    output reg          o_front_stage_bias_out
);
    localparam [31:0] BULK_F = `SFSUP_CNT(`SFSUP_BULK_FILT_US);
    localparam [31:0] OVP_F  = `SFSUP_CNT(`SFSUP_OVP_FILT_US);
    localparam [31:0] OTP_F  = `SFSUP_CNT(`SFSUP_OTP_FILT_US);

    //////////////////////////////////////////////////////////////////////////////
    // filters
    wire bulk_f;
    wire ovp_f;
    wire otp_f;
    reg  blank_r;

    sfsup_filter #(.W(32), .COUNT(BULK_F)) u_bulk (   // see RL9
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_raw   (i_bulk_cmp),
        .o_state (bulk_f)
    );
    sfsup_filter #(.W(32), .COUNT(OVP_F)) u_ovp (     // see RL13
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_raw   (i_overvoltage_level),
        .o_state (ovp_f)
    );
    sfsup_filter #(.W(32), .COUNT(OTP_F)) u_otp (     // see RL13
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_raw   (i_overtemp_level & ~blank_r),       // see RL14
        .o_state (otp_f)
    );

    //////////////////////////////////////////////////////////////////////////////
    // state
    reg  [2:0]  st_r;
    reg  [31:0] rec_cnt_r;
    reg  [31:0] blank_cnt_r;
    reg  [31:0] boost_cnt_r;
    reg  [31:0] step_cnt_r;
    reg         first_r;
    reg         bulk_d_r;
    reg         tsd_d_r;
    reg         skip_r;
    reg         started_r;

    wire bulk_rise  = bulk_f & ~bulk_d_r;
    wire bulk_fall  = ~bulk_f & bulk_d_r;
    wire tsd_end    = tsd_d_r & ~i_thermal_shutdown;
    wire prot_on    = o_protection_bias;
    wire win_fault  = prot_on & (ovp_f | (otp_f & ~blank_r));   // see RL11, RL14
    wire latch_type = (ovp_f & (OVP_LATCH != 0)) | (otp_f & (OTP_LATCH != 0));
    wire rec_done   = (st_r == `SFSUP_ST_RECOVER) && (rec_cnt_r >= RECOVER_CYCLES - 1);
    wire skip_in    = i_skip_entry_level & ~skip_r & (st_r == `SFSUP_ST_RUN);
    wire skip_out   = i_skip_exit_level & skip_r;

    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin                            // see RL22
            st_r        <= `SFSUP_ST_START;
            rec_cnt_r   <= 32'h0;
            first_r     <= 1'b1;
            bulk_d_r    <= 1'b0;
            tsd_d_r     <= 1'b0;
            skip_r      <= 1'b0;
            started_r   <= 1'b0;
        end else begin
            bulk_d_r <= bulk_f;
            tsd_d_r  <= i_thermal_shutdown;
            if (skip_in)
                skip_r <= 1'b1;
            else if (skip_out || st_r != `SFSUP_ST_RUN)
                skip_r <= 1'b0;
            if (i_supply_turn_on_level)
                first_r <= 1'b0;
            if (st_r == `SFSUP_ST_RECOVER)
                rec_cnt_r <= rec_cnt_r + 32'h1;       // see RL20
            else
                rec_cnt_r <= 32'h0;
            case (st_r)
                `SFSUP_ST_START: begin
                    if (i_supply_turn_on_level) begin
                        started_r <= 1'b1;
                        st_r      <= `SFSUP_ST_RUN;
                    end
                end
                `SFSUP_ST_RUN: begin
                    if (win_fault)                    // see RL12
                        st_r <= latch_type ? `SFSUP_ST_LATCH : `SFSUP_ST_RECOVER;
                    else if (!i_supply_turn_off_level)
                        st_r <= `SFSUP_ST_SELF;       // see RL3
                end
                `SFSUP_ST_SELF: begin
                    if (i_supply_turn_on_level)
                        st_r <= `SFSUP_ST_RUN;
                end
                `SFSUP_ST_RECOVER: begin
                    if (rec_done)
                        st_r <= `SFSUP_ST_SELF;       // see RL2
                end
                `SFSUP_ST_LATCH: begin
                    st_r <= `SFSUP_ST_LATCH;          // see RL19
                end
                default: st_r <= `SFSUP_ST_START;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // startup source
    reg startup_nxt;
    always @* begin
        startup_nxt = o_startup_on;
        if (!i_supply_turn_off_level || bulk_rise || rec_done || tsd_end)
            startup_nxt = 1'b1;                       // see RL1, RL2
        if (i_supply_turn_on_level)
            startup_nxt = 1'b0;                       // see RL1
    end

    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_startup_on           <= 1'b1;
            o_startup_current_low  <= 1'b1;
            o_startup_current_high <= 1'b0;
            o_startup_high_limit   <= 4'h0;
            step_cnt_r             <= 32'h0;
        end else begin
            o_startup_on           <= startup_nxt;
            o_startup_current_low  <= startup_nxt & i_low_current_sel;   // see RL4
            o_startup_current_high <= startup_nxt & ~i_low_current_sel;  // see RL4
            if (step_cnt_r >= STEP_CYCLES - 1) begin
                step_cnt_r <= 32'h0;
                if (i_die_hot && o_startup_high_limit != `SFSUP_LIMIT_MAX)
                    o_startup_high_limit <= o_startup_high_limit + 4'h1;  // see RL5
                else if (!i_die_hot && o_startup_high_limit != 4'h0)
                    o_startup_high_limit <= o_startup_high_limit - 4'h1;
            end else begin
                step_cnt_r <= step_cnt_r + 32'h1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // brown-out and protection bias
    reg bias_nxt;
    always @* begin
        bias_nxt = o_protection_bias;
        if (skip_in && BIAS_IN_SKIP != 0)
            bias_nxt = o_protection_bias;                                        // see RL18
        if ((i_supply_turn_on_level && first_r) || bulk_rise
            || rec_done || (skip_out && BIAS_IN_SKIP == 0))
            bias_nxt = 1'b1;                                                     // see RL16
        if (!i_supply_turn_off_level || bulk_fall || win_fault
            || (skip_in && BIAS_IN_SKIP == 0))
            bias_nxt = 1'b0;                                                     // see RL17
    end

    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_bulk_ok                 <= 1'b0;
            o_bulk_hysteresis_sink    <= 1'b0;
            o_bulk_discharge          <= 1'b1;
            o_protection_bias         <= 1'b0;
            o_thermistor_bias_doubled <= 1'b0;
            blank_r                   <= 1'b1;
            blank_cnt_r               <= 32'h0;
            boost_cnt_r               <= 32'h0;
        end else begin
            o_bulk_ok              <= bulk_f;
            o_bulk_discharge       <= ~started_r & ~i_supply_turn_on_level;      // see RL7
            o_bulk_hysteresis_sink <= (started_r | i_supply_turn_on_level)
                                      & ~bulk_f;                                 // see RL6, RL7
            o_protection_bias <= bias_nxt;
            if (!bias_nxt) begin
                blank_r     <= 1'b1;
                blank_cnt_r <= 32'h0;
                boost_cnt_r <= 32'h0;
                o_thermistor_bias_doubled <= 1'b0;
            end else begin
                if (blank_cnt_r >= BLANK_CYCLES - 1)
                    blank_r <= 1'b0;                                             // see RL14
                else
                    blank_cnt_r <= blank_cnt_r + 32'h1;
                if (boost_cnt_r < BOOST_CYCLES) begin
                    boost_cnt_r <= boost_cnt_r + 32'h1;
                    o_thermistor_bias_doubled <= 1'b1;                           // see RL15
                end else begin
                    o_thermistor_bias_doubled <= 1'b0;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // power stage permission
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_drive_enable         <= 1'b0;
            o_self_supply_mode     <= 1'b0;
            o_fault_latched        <= 1'b0;
            o_front_stage_bias_out <= 1'b0;
        end else begin
            o_drive_enable <= (st_r == `SFSUP_ST_RUN) & bulk_f & ~win_fault
                              & ~i_thermal_shutdown & ~startup_nxt;              // see RL8, RL11
            o_self_supply_mode <= (st_r == `SFSUP_ST_SELF) | (st_r == `SFSUP_ST_LATCH)
                                  | (st_r == `SFSUP_ST_RECOVER);                 // see RL3, RL19
            o_fault_latched <= (st_r == `SFSUP_ST_LATCH);
            o_front_stage_bias_out <= (st_r == `SFSUP_ST_RUN) & bulk_f & ~win_fault
                                      & ~i_light_load & ~skip_r;                 // see RL10
        end
    end
endmodule
`default_nettype wire

// ---- sfsup_sva.sv ----
// concurrent checks on the supply fault supervisor ports
`default_nettype none
module sfsup_sva (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // watched inputs
    input wire logic i_supply_turn_on_level,
    input wire logic i_bulk_cmp,
    input wire logic i_light_load,
    // watched outputs
    input wire logic o_startup_on,
    input wire logic o_bulk_ok,
    input wire logic o_bulk_hysteresis_sink,
    input wire logic o_bulk_discharge,
    input wire logic o_protection_bias,
    input wire logic o_thermistor_bias_doubled,
    input wire logic o_drive_enable,
    input wire logic o_self_supply_mode,
    input wire logic o_fault_latched,
    input wire logic o_front_stage_bias_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    logic [11:0] run_r;
    // run length of the raw brown-out level
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) run_r <= 12'h000;
        else if (!i_bulk_cmp) run_r <= 12'h000;
        else if (run_r != 12'hfff) run_r <= run_r + 12'h001;
    end
    property p_src_off; i_supply_turn_on_level |=> !o_startup_on; endproperty
    a_src_off: assert property (p_src_off) else $error("source on past turn-on");
    property p_sink; o_bulk_ok && $past(o_bulk_ok) |-> !o_bulk_hysteresis_sink; endproperty
    a_sink: assert property (p_sink) else $error("sink on with bulk ok");
    property p_dis; $fell(o_bulk_discharge) |-> $past(i_supply_turn_on_level); endproperty
    a_dis: assert property (p_dis) else $error("discharge freed early");
    property p_drv; o_drive_enable |-> o_bulk_ok || $past(o_bulk_ok); endproperty
    a_drv: assert property (p_drv) else $error("drive without bulk ok");
    property p_filt; $rose(o_bulk_ok) |-> run_r >= 12'h7ce; endproperty
    a_filt: assert property (p_filt) else $error("bulk ok rose too soon");
    property p_hold; o_fault_latched |=> o_fault_latched; endproperty
    a_hold: assert property (p_hold) else $error("latch left without reset");
    property p_latch;
        o_fault_latched && $past(o_fault_latched) |-> !o_drive_enable && o_self_supply_mode;
    endproperty
    a_latch: assert property (p_latch) else $error("latched but driving");
    property p_front;
        $past(i_light_load) || (o_fault_latched && $past(o_fault_latched))
            |-> !o_front_stage_bias_out;
    endproperty
    a_front: assert property (p_front) else $error("front bias kept");
    property p_boost; o_thermistor_bias_doubled |-> o_protection_bias; endproperty
    a_boost: assert property (p_boost) else $error("boost without bias");
    c_bulk: cover property ($rose(o_bulk_ok));
    c_latch: cover property ($rose(o_fault_latched));
    c_self: cover property (o_self_supply_mode && o_startup_on);
endmodule
`default_nettype wire

// ---- sfsup_plant.sv ----
// behavioural supply rail with its two comparators
`default_nettype none
module sfsup_plant (
    // clock
    input  wire logic i_mclk,
    // charge sources
    input  wire logic i_startup_on,
    input  wire logic i_aux_bias,
    // comparator levels
    output var  logic o_turn_on,
    output var  logic o_turn_off
);
    timeunit 1ns;
    timeprecision 100ps;
    int vcc = 0;
    // rail rises while charged, sags otherwise, so it cycles between levels
    always @(posedge i_mclk) begin
        if (i_startup_on || i_aux_bias) vcc <= (vcc < 100) ? vcc + 1 : vcc;
        else if (vcc > 0) vcc <= vcc - 1;
    end
    assign o_turn_on = (vcc >= 80);
    assign o_turn_off = (vcc >= 50);
endmodule
`default_nettype wire

// ---- sfsup_tb.sv ----
// self-checking bench for the supply fault supervisor
`default_nettype none
module supply_fault_supervisor_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_mclk = 0, i_reset = 1, i_bulk_cmp = 0, i_overvoltage_level = 0;
    logic i_overtemp_level = 0, i_thermal_shutdown = 0, i_die_hot = 0, i_skip_entry_level = 0;
    logic i_skip_exit_level = 0, i_light_load = 0, i_low_current_sel = 0, aux = 0;
    logic i_supply_turn_on_level, i_supply_turn_off_level, o_startup_on, o_startup_current_low;
    logic o_startup_current_high, o_bulk_ok, o_bulk_hysteresis_sink, o_bulk_discharge;
    logic o_protection_bias, o_thermistor_bias_doubled, o_drive_enable, o_self_supply_mode;
    logic o_fault_latched, o_front_stage_bias_out;
    logic [3:0] o_startup_high_limit;
    int n_mismatch = 0, samples_checked = 0;
    always #5 i_mclk = ~i_mclk;
    sfsup_supervisor #(.RECOVER_CYCLES(200), .BLANK_CYCLES(20), .BOOST_CYCLES(10),
        .STEP_CYCLES(5)) u_sfsup_supervisor (.i_mclk, .i_reset, .i_supply_turn_on_level,
        .i_supply_turn_off_level, .i_bulk_cmp, .i_overvoltage_level, .i_overtemp_level,
        .i_thermal_shutdown, .i_die_hot, .i_skip_entry_level, .i_skip_exit_level, .i_light_load,
        .i_low_current_sel, .o_startup_on, .o_startup_current_low, .o_startup_current_high,
        .o_startup_high_limit, .o_bulk_ok, .o_bulk_hysteresis_sink, .o_bulk_discharge,
        .o_protection_bias, .o_thermistor_bias_doubled, .o_drive_enable, .o_self_supply_mode,
        .o_fault_latched, .o_front_stage_bias_out);
    sfsup_plant u_sfsup_plant (.i_mclk, .i_startup_on(o_startup_on), .i_aux_bias(aux),
        .o_turn_on(i_supply_turn_on_level), .o_turn_off(i_supply_turn_off_level));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic wt(ref logic s, input logic v, input int n);
        int k = 0;
        while (s !== v && k < n) begin
            @(posedge i_mclk);
            #1;
            k++;
        end
        chk("wait", s, v);
        if (s !== v) results();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cyc(3);
        chk("startup_on", o_startup_on, 1);
        chk("cur_low", o_startup_current_low, 1);
        chk("cur_high", o_startup_current_high, 0);
        chk("discharge", o_bulk_discharge, 1);
        chk("drive", o_drive_enable, 0);
        @(posedge i_mclk) i_reset <= 1'b0;
        $display("test reset done");
    endtask
    task automatic t_start();
        wt(o_startup_on, 1'b0, 300);
        chk("turn_on", i_supply_turn_on_level, 1);
        @(posedge i_mclk) aux <= 1'b1;
        #1;
        chk("discharge", o_bulk_discharge, 0);
        chk("sink", o_bulk_hysteresis_sink, 1);
        chk("bias", o_protection_bias, 1);
        chk("boost", o_thermistor_bias_doubled, 1);
        cyc(12);
        chk("boost", o_thermistor_bias_doubled, 0);
        $display("test start done");
    endtask
    task automatic t_bulk();
        @(posedge i_mclk) i_bulk_cmp <= 1'b1;
        repeat (100) @(posedge i_mclk);
        i_bulk_cmp <= 1'b0;
        cyc(2100);
        chk("glitch", o_bulk_ok, 0);
        @(posedge i_mclk) i_bulk_cmp <= 1'b1;
        cyc(1990);
        chk("early", o_bulk_ok, 0);
        wt(o_bulk_ok, 1'b1, 20);
        cyc(1);
        chk("sink", o_bulk_hysteresis_sink, 0);
        wt(o_drive_enable, 1'b1, 5);
        @(posedge i_mclk) i_light_load <= 1'b1;
        cyc(2);
        chk("front", o_front_stage_bias_out, 0);
        @(posedge i_mclk) i_light_load <= 1'b0;
        cyc(3);
        chk("front", o_front_stage_bias_out, 1);
        $display("test bulk done");
    endtask
    task automatic t_otp();
        @(posedge i_mclk) i_overtemp_level <= 1'b1;
        cyc(1990);
        chk("drive", o_drive_enable, 1);
        wt(o_drive_enable, 1'b0, 30);
        @(posedge i_mclk) i_overtemp_level <= 1'b0;
        #1;
        chk("bias", o_protection_bias, 0);
        chk("latched", o_fault_latched, 0);
        wt(o_protection_bias, 1'b1, 400);
        cyc(2100);
        wt(o_drive_enable, 1'b1, 400);
        chk("bias", o_protection_bias, 1);
        $display("test otp done");
    endtask
    task automatic t_misc();
        cyc(30);
        chk("bias", o_protection_bias, 1);
        @(posedge i_mclk) i_die_hot <= 1'b1;
        cyc(12);
        chk("limit_mid", (o_startup_high_limit >= 4'h2 && o_startup_high_limit <= 4'h3), 1);
        cyc(80);
        chk("limit_max", o_startup_high_limit, 4'hf);
        @(posedge i_mclk) i_die_hot <= 1'b0;
        cyc(80);
        chk("limit_low", o_startup_high_limit, 4'h0);
        @(posedge i_mclk) i_thermal_shutdown <= 1'b1;
        cyc(2);
        chk("drive_tsd", o_drive_enable, 0);
        @(posedge i_mclk) i_thermal_shutdown <= 1'b0;
        cyc(2);
        chk("startup_tsd", o_startup_on, 0);
        chk("drive_tsd", o_drive_enable, 1);
        @(posedge i_mclk) i_skip_entry_level <= 1'b1;
        cyc(2);
        chk("front_skip", o_front_stage_bias_out, 0);
        chk("bias_skip", o_protection_bias, 1);
        @(posedge i_mclk) begin
            i_skip_entry_level <= 1'b0;
            i_skip_exit_level <= 1'b1;
        end
        cyc(3);
        chk("front_skip", o_front_stage_bias_out, 1);
        chk("bias_skip", o_protection_bias, 1);
        @(posedge i_mclk) i_skip_exit_level <= 1'b0;
        $display("test misc done");
    endtask
    task automatic t_ovp();
        logic [1:0] seen = 2'b00;
        @(posedge i_mclk) i_overvoltage_level <= 1'b1;
        wt(o_fault_latched, 1'b1, 2100);
        cyc(1);
        chk("drive", o_drive_enable, 0);
        chk("self", o_self_supply_mode, 1);
        @(posedge i_mclk) i_overvoltage_level <= 1'b0;
        aux <= 1'b0;
        repeat (2) begin
            repeat (150) begin
                cyc(1);
                seen = seen | {o_startup_on, ~o_startup_on};
                chk("cur_low", o_startup_current_low, o_startup_on & i_low_current_sel);
                chk("cur_high", o_startup_current_high, o_startup_on & ~i_low_current_sel);
            end
            @(posedge i_mclk) i_low_current_sel <= 1'b1;
        end
        chk("cycling", seen, 2'b11);
        chk("latched", o_fault_latched, 1);
        chk("front", o_front_stage_bias_out, 0);
        @(posedge i_mclk) i_reset <= 1'b1;
        #1;
        chk("latched", o_fault_latched, 0);
        @(posedge i_mclk) i_reset <= 1'b0;
        $display("test ovp done");
    endtask
    initial begin
        t_reset();
        t_start();
        t_bulk();
        t_otp();
        t_misc();
        t_ovp();
        results();
    end
endmodule
bind sfsup_supervisor sfsup_sva u_sfsup_sva (.i_mclk, .i_reset, .i_supply_turn_on_level,
    .i_bulk_cmp, .i_light_load, .o_startup_on, .o_bulk_ok, .o_bulk_hysteresis_sink,
    .o_bulk_discharge, .o_protection_bias, .o_thermistor_bias_doubled, .o_drive_enable,
    .o_self_supply_mode, .o_fault_latched, .o_front_stage_bias_out);
`default_nettype wire
